// ===== rtl/sp_split_point.sv
// Top of the group 0 and group 1 priority split point registers.
// Assumes the core presents one access per valid cycle and the routing
// controls are stable while the access is valid.
`timescale 1ns/1ns
`default_nettype none

module sp_split_point (
  // Clock, reset and enable
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  // System register access
  input  wire logic        i_req_valid,
  input  wire logic        i_req_write,
  input  wire logic [2:0]  i_op1,
  input  wire logic [3:0]  i_crn,
  input  wire logic [3:0]  i_crm,
  input  wire logic [2:0]  i_op2,
  input  wire logic [1:0]  i_req_level,
  input  wire logic        i_req_ns,
  input  wire logic [31:0] i_wdata,
  // Configuration and routing controls
  input  wire logic        i_monitor_present,
  input  wire logic        i_sysreg_enable_kernel,
  input  wire logic        i_sysreg_enable_hyp,
  input  wire logic        i_sysreg_enable_monitor,
  input  wire logic        i_fiq_route_to_hyp,
  input  wire logic        i_irq_route_to_hyp,
  input  wire logic        i_fiq_route_to_monitor,
  input  wire logic        i_irq_route_to_monitor,
  input  wire logic        i_trap_group0_access,
  input  wire logic        i_trap_group1_access,
  input  wire logic        i_secure_shared_split,
  input  wire logic        i_nonsecure_shared_split,
  input  wire logic        i_shared_split_ctl,
  input  wire logic [2:0]  i_priority_width_field,
  // Virtual split points
  input  wire logic [2:0]  i_virtual_group0_point,
  input  wire logic [2:0]  i_virtual_group1_point,
  output logic             o_virtual_access,
  output logic             o_virtual_group1,
  output logic             o_virtual_write,
  output logic [2:0]       o_virtual_wdata,
  // Access answer
  output logic             o_resp_valid,
  output logic [31:0]      o_resp_rdata,
  output logic             o_resp_trap,
  output logic [1:0]       o_resp_trap_level,
  output logic             o_resp_undef,
  // Preemption grouping
  output logic [2:0]       o_group0_point,
  output logic [2:0]       o_group1_point,
  output logic [7:0]       o_group0_preempt_mask,
  output logic [7:0]       o_group1_preempt_mask
);
  import sp_pkg::*;

  // ---------------------------------------------------------------------
  // Decode and minimums
  // ---------------------------------------------------------------------
  logic                 hit_g0;
  logic                 hit_g1;
  logic [2:0]           min_g0;
  logic [2:0]           min_g1ns;
  logic [2:0]           capped;
  logic [2:0]           wfield;
  logic [2:0]           point_q   [SP_SLOTS];
  logic [2:0]           point_min [SP_SLOTS];
  logic [SP_SLOTS-1:0]  store_we;

  sp_access_decode u_decode (
    .i_valid  (i_req_valid),
    .i_op1    (i_op1),
    .i_crn    (i_crn),
    .i_crm    (i_crm),
    .i_op2    (i_op2),
    .o_hit_g0 (hit_g0),
    .o_hit_g1 (hit_g1)
  );

  assign wfield = i_wdata[SP_FIELD_MSB:SP_FIELD_LSB];

  // The width field reports implemented bits minus one; eight bits gives zero.
  always_comb begin
    min_g0   = (i_priority_width_field >= SP_MIN_BASE) ? 3'h0
               : SP_MIN_BASE - i_priority_width_field;
    min_g1ns = (min_g0 == SP_POINT_MAX) ? SP_POINT_MAX : min_g0 + 3'h1;
    capped   = (point_q[SP_SLOT_G0] == SP_POINT_MAX) ? SP_POINT_MAX
               : point_q[SP_SLOT_G0] + 3'h1;
  end

  assign point_min[SP_SLOT_G0]  = min_g0;
  assign point_min[SP_SLOT_G1S] = min_g0;
  assign point_min[SP_SLOT_G1N] = min_g1ns;

  genvar gi;
  generate
    for (gi = 0; gi < SP_SLOTS; gi++) begin : g_store
      sp_point_store u_store (
        .i_core_clk (i_core_clk),
        .i_ce       (i_ce),
        .i_we       (store_we[gi]),
        .i_wfield   (wfield),
        .i_min      (point_min[gi]),
        .o_point    (point_q[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Access outcome
  // ---------------------------------------------------------------------
  sp_outcome_e outcome;
  logic [1:0]  trap_level;
  logic [1:0]  slot;
  logic        ns_eff;
  logic        kern_ns;
  logic        route_hyp;
  logic        route_mon;
  logic        shared_ns;
  logic        alias_s;

  always_comb begin
    ns_eff     = (i_req_level == SP_LVL_HYP) ? 1'b1
                 : (i_req_level == SP_LVL_MON) ? 1'b0 : i_req_ns;
    kern_ns    = (i_req_level == SP_LVL_KERN) && ns_eff;
    route_hyp  = hit_g1 ? i_irq_route_to_hyp : i_fiq_route_to_hyp;
    route_mon  = i_monitor_present && (hit_g1 ? i_irq_route_to_monitor : i_fiq_route_to_monitor);
    shared_ns  = i_monitor_present ? i_nonsecure_shared_split : i_shared_split_ctl;
    alias_s    = i_monitor_present && i_secure_shared_split && !ns_eff
                 && (i_req_level == SP_LVL_KERN);
    trap_level = SP_RESP_RESET;
    outcome    = SP_OUT_PHYS;
    if (i_req_level == SP_LVL_USER) begin
      outcome = SP_OUT_UNDEF;
    end else if ((i_req_level == SP_LVL_KERN) && !i_sysreg_enable_kernel) begin
      outcome    = hit_g1 ? SP_OUT_UNDEF : SP_OUT_TRAP;
      trap_level = SP_LVL_KERN;
    end else if ((i_req_level == SP_LVL_HYP) && !i_sysreg_enable_hyp) begin
      outcome    = SP_OUT_TRAP;
      trap_level = SP_LVL_HYP;
    end else if ((i_req_level == SP_LVL_MON) && !i_sysreg_enable_monitor) begin
      outcome    = SP_OUT_TRAP;
      trap_level = SP_LVL_MON;
    end else if (kern_ns && (hit_g1 ? i_trap_group1_access : i_trap_group0_access)) begin
      outcome    = SP_OUT_TRAP;
      trap_level = SP_LVL_HYP;
    end else if (route_mon && (i_req_level != SP_LVL_MON)
                 && ((i_req_level == SP_LVL_HYP) || !ns_eff || !route_hyp)) begin
      outcome    = SP_OUT_TRAP;
      trap_level = SP_LVL_MON;
    end else if (kern_ns && route_hyp) begin
      outcome = SP_OUT_VIRT;
    end else if (hit_g1 && ns_eff && (i_req_level != SP_LVL_MON) && shared_ns) begin
      outcome = SP_OUT_CAPPED;
    end else if (hit_g1 && alias_s) begin
      outcome = SP_OUT_ALIAS;
    end
    if (!hit_g1 || alias_s) begin
      slot = 2'(SP_SLOT_G0);
    end else if (ns_eff) begin
      slot = 2'(SP_SLOT_G1N);
    end else begin
      slot = 2'(SP_SLOT_G1S);
    end
  end

  // Writes only land on the physical copy the access resolved to.
  always_comb begin
    store_we = '0;
    if ((hit_g0 || hit_g1) && i_req_write
        && ((outcome == SP_OUT_PHYS) || (outcome == SP_OUT_ALIAS))) begin
      store_we[slot] = 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Answer registers
  // ---------------------------------------------------------------------
  logic       resp_valid_reg,  resp_valid_next;
  logic [2:0] resp_field_reg,  resp_field_next;
  logic       resp_trap_reg,   resp_trap_next;
  logic [1:0] resp_level_reg,  resp_level_next;
  logic       resp_undef_reg,  resp_undef_next;
  logic       virt_acc_reg,    virt_acc_next;
  logic       virt_g1_reg,     virt_g1_next;
  logic       virt_wr_reg,     virt_wr_next;
  logic [2:0] virt_wdata_reg,  virt_wdata_next;

  always_comb begin
    resp_valid_next = resp_valid_reg;
    resp_field_next = resp_field_reg;
    resp_trap_next  = resp_trap_reg;
    resp_level_next = resp_level_reg;
    resp_undef_next = resp_undef_reg;
    virt_acc_next   = virt_acc_reg;
    virt_g1_next    = virt_g1_reg;
    virt_wr_next    = virt_wr_reg;
    virt_wdata_next = virt_wdata_reg;
    if (i_ce) begin
      resp_valid_next = hit_g0 || hit_g1;
      resp_field_next = 3'h0;
      resp_trap_next  = 1'b0;
      resp_level_next = SP_RESP_RESET;
      resp_undef_next = 1'b0;
      virt_acc_next   = 1'b0;
      virt_g1_next    = 1'b0;
      virt_wr_next    = 1'b0;
      virt_wdata_next = 3'h0;
      if (hit_g0 || hit_g1) begin
        case (outcome)
          SP_OUT_PHYS, SP_OUT_ALIAS: begin
            resp_field_next = i_req_write ? 3'h0 : point_q[slot];
          end
          SP_OUT_CAPPED: begin
            resp_field_next = i_req_write ? 3'h0 : capped;
          end
          SP_OUT_VIRT: begin
            virt_acc_next   = 1'b1;
            virt_g1_next    = hit_g1;
            virt_wr_next    = i_req_write;
            virt_wdata_next = i_req_write ? wfield : 3'h0;
            if (!i_req_write) begin
              resp_field_next = hit_g1 ? i_virtual_group1_point : i_virtual_group0_point;
            end
          end
          SP_OUT_TRAP: begin
            resp_trap_next  = 1'b1;
            resp_level_next = trap_level;
          end
          SP_OUT_UNDEF: begin
            resp_undef_next = 1'b1;
          end
          default: begin
            resp_undef_next = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      resp_valid_reg <= 1'b0;
      resp_field_reg <= 3'h0;
      resp_trap_reg  <= 1'b0;
      resp_level_reg <= SP_RESP_RESET;
      resp_undef_reg <= 1'b0;
      virt_acc_reg   <= 1'b0;
      virt_g1_reg    <= 1'b0;
      virt_wr_reg    <= 1'b0;
      virt_wdata_reg <= 3'h0;
    end else begin
      resp_valid_reg <= resp_valid_next;
      resp_field_reg <= resp_field_next;
      resp_trap_reg  <= resp_trap_next;
      resp_level_reg <= resp_level_next;
      resp_undef_reg <= resp_undef_next;
      virt_acc_reg   <= virt_acc_next;
      virt_g1_reg    <= virt_g1_next;
      virt_wr_reg    <= virt_wr_next;
      virt_wdata_reg <= virt_wdata_next;
    end
  end

  assign o_resp_valid      = resp_valid_reg;
  assign o_resp_rdata      = {{(SP_REG_W - SP_FIELD_W){1'b0}}, resp_field_reg};
  assign o_resp_trap       = resp_trap_reg;
  assign o_resp_trap_level = resp_level_reg;
  assign o_resp_undef      = resp_undef_reg;
  assign o_virtual_access  = virt_acc_reg;
  assign o_virtual_group1  = virt_g1_reg;
  assign o_virtual_write   = virt_wr_reg;
  assign o_virtual_wdata   = virt_wdata_reg;

  // ---------------------------------------------------------------------
  // Preemption grouping
  // ---------------------------------------------------------------------
  // The group 1 copy in force follows the i_req_ns input of the current cycle
  // side; the group 0 copy is used instead when i_shared_split_ctl is set.
  assign o_group0_point = point_q[SP_SLOT_G0];
  assign o_group1_point = i_shared_split_ctl ? point_q[SP_SLOT_G0]
                          : point_q[i_req_ns ? SP_SLOT_G1N : SP_SLOT_G1S];

  genvar bi;
  generate
    for (bi = 0; bi < SP_PRIO_W; bi++) begin : g_mask
      assign o_group0_preempt_mask[bi] = (3'(bi) > o_group0_point) && (bi > 0);
      assign o_group1_preempt_mask[bi] = (3'(bi) > o_group1_point) && (bi > 0);
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  sequence s_take_g0;
    i_ce && i_req_valid && (i_op1 == SP_OP1) && (i_crn == SP_CRN)
      && (i_crm == SP_CRM_G0) && (i_op2 == SP_OP2);
  endsequence

  sequence s_take_g1;
    i_ce && i_req_valid && (i_op1 == SP_OP1) && (i_crn == SP_CRN)
      && (i_crm == SP_CRM_G1) && (i_op2 == SP_OP2);
  endsequence

  property p_g0_decode;
    s_take_g0 |=> o_resp_valid;
  endproperty
  a_g0_decode: assert property (p_g0_decode) else $error("group 0 access not answered");

  property p_g1_decode;
    s_take_g1 |=> o_resp_valid;
  endproperty
  a_g1_decode: assert property (p_g1_decode) else $error("group 1 access not answered");

  property p_reserved_zero;
    o_resp_valid |-> (o_resp_rdata[31:3] == 29'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_g0_clamp;
    (i_ce && store_we[SP_SLOT_G0] && (wfield < min_g0))
      |=> (point_q[SP_SLOT_G0] == $past(min_g0));
  endproperty
  a_g0_clamp: assert property (p_g0_clamp) else $error("low write not clamped");

  property p_ns_min;
    (i_ce && store_we[SP_SLOT_G1N])
      |=> (point_q[SP_SLOT_G1N] >= $past(min_g1ns)) && (point_q[SP_SLOT_G1N] >= $past(wfield));
  endproperty
  a_ns_min: assert property (p_ns_min) else $error("non-secure group 1 below minimum");

  property p_kernel_undef;
    (s_take_g1 ##0 (i_req_level == SP_LVL_KERN) && !i_sysreg_enable_kernel)
      |=> o_resp_undef && !o_resp_trap;
  endproperty
  a_kernel_undef: assert property (p_kernel_undef) else $error("group 1 disable not undefined");

  property p_hyp_disable;
    ((s_take_g0 or s_take_g1) ##0 (i_req_level == SP_LVL_HYP) && !i_sysreg_enable_hyp)
      |=> o_resp_trap && (o_resp_trap_level == SP_LVL_HYP);
  endproperty
  a_hyp_disable: assert property (p_hyp_disable) else $error("hypervisor disable not trapped");

  property p_virt_g0;
    (s_take_g0 ##0 (outcome == SP_OUT_VIRT))
      |=> (o_virtual_access && !o_virtual_group1) ##1 (!o_virtual_access || $past(virt_acc_next));
  endproperty
  a_virt_g0: assert property (p_virt_g0) else $error("virtual group 0 access missing");

  property p_capped;
    (s_take_g1 ##0 (outcome == SP_OUT_CAPPED) && !i_req_write)
      |=> (o_resp_rdata[2:0] == $past(capped)) && !o_resp_trap;
  endproperty
  a_capped: assert property (p_capped) else $error("capped read value wrong");

  property p_shared;
    i_shared_split_ctl |-> (o_group1_point == o_group0_point);
  endproperty
  a_shared: assert property (p_shared) else $error("shared split not followed");

  property p_no_preempt;
    (o_group0_point == SP_POINT_MAX) |-> (o_group0_preempt_mask == 8'h00);
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("point 7 still preempts");

endmodule : sp_split_point

`default_nettype wire

// ===== rtl/sp_pkg.sv
// Constants and types shared by the split point register block.
// Assumes one core clock and one synchronous reset for every user of the package.
//
// Summary of operation
// - Decode group 0 point from encoding.
// - Decode group 1 point from encoding.
// - Routed non-secure kernel group 0 goes virtual.
// - Routed non-secure kernel group 1 goes virtual.
// - Field in bits 2:0, rest zero.
// - Group 0 minimum follows priority width.
// - Writes below minimum store the minimum.
// - Split field value is unknown after reset.
// - Separate group 1 field splits group 1.
// - Non-secure group 1 minimum is one higher.
// - Secure shared split aliases group 1 onto 0.
// - Non-secure shared split reads capped, ignores writes.
// - Shared split with monitor routing traps monitor.
// - Hypervisor routing sends non-secure kernel accesses virtual.
// - Without monitor, shared control selects same behaviour.
// - Kernel disable traps group 0, undefined group 1.
// - Hypervisor disable traps to hypervisor.
// - Monitor disable traps to monitor.
// - Group trap bits send kernel to hypervisor.
// - Fiq monitor routing traps group 0 accesses.
// - Irq monitor routing traps group 1 accesses.
// - Point N: bits above N preempt.
// - Priority width field is bits minus one.
// - Shared control makes group 0 govern both.

package sp_pkg;

  // ---------------------------------------------------------------------
  // Instruction encodings
  // ---------------------------------------------------------------------
  localparam logic [2:0] SP_OP1      = 3'h0;
  localparam logic [3:0] SP_CRN      = 4'hc;
  localparam logic [3:0] SP_CRM_G0   = 4'h8;
  localparam logic [3:0] SP_CRM_G1   = 4'hc;
  localparam logic [2:0] SP_OP2      = 3'h3;

  // ---------------------------------------------------------------------
  // Field layout and values
  // ---------------------------------------------------------------------
  localparam int         SP_REG_W    = 32;
  localparam int         SP_FIELD_W  = 3;
  localparam int         SP_FIELD_LSB = 0;
  localparam int         SP_FIELD_MSB = 2;
  localparam int         SP_PRIO_W   = 8;
  localparam logic [2:0] SP_POINT_MAX = 3'h7;
  localparam logic [2:0] SP_MIN_BASE = 3'h6;
  localparam logic [1:0] SP_RESP_RESET = 2'h0;

  // Exception levels as presented by the core.
  localparam logic [1:0] SP_LVL_USER = 2'h0;
  localparam logic [1:0] SP_LVL_KERN = 2'h1;
  localparam logic [1:0] SP_LVL_HYP  = 2'h2;
  localparam logic [1:0] SP_LVL_MON  = 2'h3;

  // Storage slots for the physical copies.
  localparam int         SP_SLOT_G0  = 0;
  localparam int         SP_SLOT_G1S = 1;
  localparam int         SP_SLOT_G1N = 2;
  localparam int         SP_SLOTS    = 3;

  typedef enum logic [2:0] {
    SP_OUT_PHYS,
    SP_OUT_ALIAS,
    SP_OUT_VIRT,
    SP_OUT_CAPPED,
    SP_OUT_TRAP,
    SP_OUT_UNDEF
  } sp_outcome_e;

endpackage : sp_pkg

// ===== rtl/sp_access_decode.sv
// Decoder of the system register encoding for the two split point registers.
// Assumes the encoding fields are stable while the request is valid.
`timescale 1ns/1ns
`default_nettype none

module sp_access_decode (
  // Encoding
  input  wire logic       i_valid,
  input  wire logic [2:0] i_op1,
  input  wire logic [3:0] i_crn,
  input  wire logic [3:0] i_crm,
  input  wire logic [2:0] i_op2,
  // Decoded selects
  output logic            o_hit_g0,
  output logic            o_hit_g1
);
  import sp_pkg::*;

  logic common;

  always_comb begin
    common   = i_valid && (i_op1 == SP_OP1) && (i_crn == SP_CRN) && (i_op2 == SP_OP2);
    o_hit_g0 = common && (i_crm == SP_CRM_G0);
    o_hit_g1 = common && (i_crm == SP_CRM_G1);
  end

endmodule : sp_access_decode

`default_nettype wire

// ===== rtl/sp_point_store.sv
// One split point field with its minimum clamp on write.
// Assumes the minimum is stable in the cycle of the write.
`timescale 1ns/1ns
`default_nettype none

module sp_point_store (
  // Clock
  input  wire logic       i_core_clk,
  input  wire logic       i_ce,
  // Write port
  input  wire logic       i_we,
  input  wire logic [2:0] i_wfield,
  input  wire logic [2:0] i_min,
  // Stored value
  output logic      [2:0] o_point
);

  logic [2:0] point_reg;
  logic [2:0] point_next;

  always_comb begin
    point_next = point_reg;
    if (i_ce && i_we) begin
      point_next = (i_wfield < i_min) ? i_min : i_wfield;
    end
  end

  // No reset: the field holds whatever it held until software writes it.
  always_ff @(posedge i_core_clk) begin
    point_reg <= point_next;
  end

  assign o_point = point_reg;

endmodule : sp_point_store

`default_nettype wire

// ===== tb/sp_core_model.sv
// Core that issues split point register reads and writes.
// Assumes a free running core clock; requests change at its falling edge.
`timescale 1ns/1ns
`default_nettype none

module sp_core_model (
  // Clock
  input  wire logic   i_core_clk,
  // Request
  output logic        o_valid,
  output logic        o_write,
  output logic [3:0]  o_crm,
  output logic [2:0]  o_op2,
  output logic [1:0]  o_level,
  output logic        o_ns,
  output logic [31:0] o_wdata,
  // Virtual copies kept by the hypervisor
  output logic [2:0]  o_vpoint0,
  output logic [2:0]  o_vpoint1
);
  initial begin
    {o_valid, o_write, o_crm, o_op2, o_level, o_ns} = 12'h000;
    o_wdata = 32'h0000_0000;
    {o_vpoint0, o_vpoint1} = 6'h00;
  end

  // ---------------------------------------------------------------
  // Request tasks
  // ---------------------------------------------------------------
  task automatic access(input logic [3:0] crm, input logic [2:0] op2, input logic wr,
                        input logic [1:0] lvl, input logic ns, input logic [31:0] wd);
    @(negedge i_core_clk);
    o_valid = 1'b1;
    o_write = wr;
    o_crm = crm;
    o_op2 = op2;
    o_level = lvl;
    o_ns = ns;
    o_wdata = wd;
    o_vpoint0 = 3'($urandom);
    o_vpoint1 = 3'($urandom);
  endtask : access

  // Released fields are inverted so a stale value never looks like a request.
  task automatic idle();
    @(negedge i_core_clk);
    o_valid = 1'b0;
    o_write = ~o_write;
    o_crm = ~o_crm;
    o_wdata = ~o_wdata;
  endtask : idle
endmodule : sp_core_model
`default_nettype wire

// ===== tb/sp_split_point_bench.sv
// Self-checking bench for the split point register block.
// Assumes sp_core_model issues accesses; the bench sets every routing control.
`timescale 1ns/1ns
`default_nettype none

module sp_split_point_bench;
  import sp_pkg::*;

  typedef struct packed {
    logic [31:0] rd;
    logic        trap;
    logic [1:0]  tlvl;
    logic        undef;
    logic        virt;
    logic        vwr;
    logic        vg1;
    logic [2:0]  vwd;
    logic [2:0]  g0;
    logic [2:0]  g1s;
    logic [2:0]  g1n;
  } sp_exp_s;

  logic        clk, srst, mon, en_k, en_h, en_m, fh, ih, fm, im, t0, t1, ss, nss, ctl;
  logic        valid, wr, ns, v_acc, v_g1, v_wr, r_valid, r_trap, r_undef;
  logic [1:0]  lvl, r_tlvl;
  logic [2:0]  pw, p0, p1s, p1n, op2, vp0, vp1, v_wd, g0pt, g1pt;
  logic [3:0]  crm;
  logic [7:0]  m0k, m1k;
  logic [31:0] wd, r_data;
  sp_exp_s     q[$];
  int          bad_count, samples_checked;

  sp_core_model core (
    .i_core_clk(clk), .o_valid(valid), .o_write(wr), .o_crm(crm), .o_op2(op2),
    .o_level(lvl), .o_ns(ns), .o_wdata(wd), .o_vpoint0(vp0), .o_vpoint1(vp1)
  );

  sp_split_point uut (
    .i_core_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_req_valid(valid), .i_req_write(wr),
    .i_op1(SP_OP1), .i_crn(SP_CRN), .i_crm(crm), .i_op2(op2), .i_req_level(lvl),
    .i_req_ns(ns), .i_wdata(wd), .i_monitor_present(mon), .i_sysreg_enable_kernel(en_k),
    .i_sysreg_enable_hyp(en_h), .i_sysreg_enable_monitor(en_m), .i_fiq_route_to_hyp(fh),
    .i_irq_route_to_hyp(ih), .i_fiq_route_to_monitor(fm), .i_irq_route_to_monitor(im),
    .i_trap_group0_access(t0), .i_trap_group1_access(t1), .i_secure_shared_split(ss),
    .i_nonsecure_shared_split(nss), .i_shared_split_ctl(ctl), .i_priority_width_field(pw),
    .i_virtual_group0_point(vp0), .i_virtual_group1_point(vp1), .o_virtual_access(v_acc),
    .o_virtual_group1(v_g1), .o_virtual_write(v_wr), .o_virtual_wdata(v_wd),
    .o_resp_valid(r_valid), .o_resp_rdata(r_data), .o_resp_trap(r_trap),
    .o_resp_trap_level(r_tlvl), .o_resp_undef(r_undef), .o_group0_point(g0pt),
    .o_group1_point(g1pt), .o_group0_preempt_mask(m0k), .o_group1_preempt_mask(m1k)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  function automatic logic [2:0] lift(input logic [2:0] f, input logic [2:0] m);
    return (f < m) ? m : f;
  endfunction : lift

  // Traps and monitor routing are biased rare so physical paths stay busy.
  task automatic shuffle();
    logic [31:0] r;
    r = $urandom;
    {mon, fh, ih, ss, nss, ctl, pw} = r[8:0];
    {fm, im, t0, t1} = {&r[10:9], &r[12:11], &r[14:13], &r[16:15]};
    {en_k, en_h, en_m} = {|r[18:17], |r[20:19], |r[22:21]};
  endtask : shuffle

  // Issues one access and notes the answer the rules call for.
  task automatic run(input logic [1:0] kind, input logic w, input logic [1:0] lv,
                     input logic n, input logic [31:0] d, input logic rnd);
    sp_exp_s    e;
    logic       g1, sn, rh, rm, tg;
    logic [2:0] m0, f;
    core.access(kind[0] ? SP_CRM_G1 : SP_CRM_G0, kind[1] ? 3'h4 : SP_OP2, w, lv, n, d);
    if (rnd) shuffle();
    if (!kind[1]) begin
      e = '0;
      g1 = kind[0];
      sn = (lv == SP_LVL_HYP) || (lv == SP_LVL_KERN && n);
      m0 = (pw >= 3'h6) ? 3'h0 : 3'h6 - pw;
      f = d[2:0];
      rh = g1 ? ih : fh;
      rm = mon && (g1 ? im : fm);
      tg = g1 ? t1 : t0;
      if (lv == SP_LVL_USER) begin
        e.undef = 1'b1;
      end else if (lv == SP_LVL_KERN && !en_k) begin
        {e.undef, e.trap, e.tlvl} = {g1, !g1, SP_LVL_KERN};
      end else if ((lv == SP_LVL_HYP && !en_h) || (lv == SP_LVL_KERN && sn && tg)) begin
        {e.trap, e.tlvl} = {1'b1, SP_LVL_HYP};
      end else if ((lv == SP_LVL_MON && !en_m) ||
                   (rm && (lv == SP_LVL_HYP || (lv == SP_LVL_KERN && !(sn && rh))))) begin
        {e.trap, e.tlvl} = {1'b1, SP_LVL_MON};
      end else if (lv == SP_LVL_KERN && sn && rh) begin
        {e.virt, e.vwr, e.vg1, e.vwd} = {1'b1, w, g1, f};
        if (!w) e.rd = {29'h0000_0000, g1 ? vp1 : vp0};
      end else if (g1 && sn && (mon ? nss : ctl)) begin
        if (!w) e.rd = {29'h0000_0000, (p0 == 3'h7) ? 3'h7 : p0 + 3'h1};
      end else if (!g1 || (lv == SP_LVL_KERN && !sn && mon && ss)) begin
        if (w) p0 = lift(f, m0);
        else e.rd = {29'h0000_0000, p0};
      end else if (sn) begin
        if (w) p1n = lift(f, m0 + 3'h1);
        else e.rd = {29'h0000_0000, p1n};
      end else begin
        if (w) p1s = lift(f, m0);
        else e.rd = {29'h0000_0000, p1s};
      end
      {e.g0, e.g1s, e.g1n} = {p0, p1s, p1n};
      q.push_back(e);
    end
  endtask : run

  // ---------------------------------------------------------------
  // Answer watcher
  // ---------------------------------------------------------------
  initial begin
    sp_exp_s    e;
    logic [2:0] g1x;
    forever begin
      @(negedge clk);
      // Step past the falling edge so the request fields that steer group 1 have settled.
      #1;
      if (r_valid === 1'b1 && q.size() == 0) begin
        cmp(32'(r_valid), 32'h0000_0000, "answer without request");
      end else if (r_valid === 1'b1) begin
        e = q.pop_front();
        cmp(r_data, e.rd, "read data");
        cmp(32'(r_trap), 32'(e.trap), "trap");
        if (e.trap) cmp(32'(r_tlvl), 32'(e.tlvl), "trap level");
        cmp(32'(r_undef), 32'(e.undef), "undefined");
        cmp(32'(v_acc), 32'(e.virt), "virtual access");
        if (e.virt) cmp(32'({v_g1, v_wr}), 32'({e.vg1, e.vwr}), "virtual kind");
        if (e.vwr) cmp(32'(v_wd), 32'(e.vwd), "virtual field");
        cmp(32'(g0pt), 32'(e.g0), "group 0 point");
        cmp(32'(m0k), 32'(8'(8'hff << (e.g0 + 4'h1))), "group 0 mask");
        g1x = ctl ? e.g0 : (ns ? e.g1n : e.g1s);
        cmp(32'(g1pt), 32'(g1x), "group 1 point");
        cmp(32'(m1k), 32'(8'hfe & (8'hff << (g1x + 4'h1))), "group 1 mask");
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("FAIL %0t run did not finish", $time);
    close_out();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    {mon, en_k, en_h, en_m, fh, ih, fm, im, t0, t1, ss, nss, ctl} = 13'h1e00;
    pw = 3'h4;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(32'h279a));
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    run(2'h0, 1'b1, SP_LVL_MON, 1'b0, 32'hffff_fff5, 1'b0);
    run(2'h1, 1'b1, SP_LVL_MON, 1'b0, 32'h0000_0000, 1'b0);
    run(2'h1, 1'b1, SP_LVL_HYP, 1'b1, 32'h0000_0000, 1'b0);
    run(2'h0, 1'b1, SP_LVL_KERN, 1'b0, 32'h0000_0000, 1'b0);
    run(2'h1, 1'b0, SP_LVL_MON, 1'b0, 32'h0000_0000, 1'b0);
    run(2'h1, 1'b0, SP_LVL_HYP, 1'b1, 32'h0000_0000, 1'b0);
    for (int i = 0; i < 600; i++) begin
      run(2'($urandom), 1'($urandom), 2'($urandom), 1'($urandom), $urandom, 1'b1);
      if (i % 16 == 15) core.idle();
    end
    core.idle();
    repeat (3) @(negedge clk);
    cmp(32'(q.size()), 32'h0000_0000, "answers missing");
    close_out();
  end
endmodule : sp_split_point_bench
`default_nettype wire
